// ---- design/ssp_eval.sv ----
`timescale 1ns/1ps
`default_nettype none
// =====================================================================
// Threshold comparison and current limit breakpoints
// =====================================================================
module ssp_eval #(
    parameter int VW = 16
) (
    input wire logic [VW-1:0] stack_v,
    input wire logic [VW-1:0] cell_sum_v,
    input wire logic [ssp_pkg::THR_N-1:0][VW-1:0] thr,
    output ssp_pkg::ssp_flags_t flags,
    output logic [6:0] chg_pct,
    output logic [6:0] dchg_pct
);

    logic [VW-1:0] diff;
    logic [VW+6:0] num_c;
    logic [VW+6:0] num_d;

    // Zone and trigger comparisons
    always_comb
    begin
        diff = (stack_v >= cell_sum_v) ? stack_v - cell_sum_v : cell_sum_v - stack_v;
        flags.over_fault = stack_v > thr[ssp_pkg::T_OVER];
        flags.hi_fault = stack_v > thr[ssp_pkg::T_HI_FAULT];
        flags.hi_warn = stack_v > thr[ssp_pkg::T_HI_WARN];
        flags.lo_warn = stack_v < thr[ssp_pkg::T_LO_WARN];
        flags.lo_fault = stack_v < thr[ssp_pkg::T_LO_FAULT];
        flags.under_fault = stack_v < thr[ssp_pkg::T_UNDER];
        flags.lockout = stack_v < thr[ssp_pkg::T_LOCKOUT];
        flags.user_hi = stack_v > thr[ssp_pkg::T_USER_HI];
        flags.user_lo = stack_v < thr[ssp_pkg::T_USER_LO];
        flags.mismatch = diff > thr[ssp_pkg::T_MISMATCH];
    end

    // Charge limit ramps from full at high breakpoint to zero at max
    always_comb
    begin
        num_c = (VW+7)'(ssp_pkg::PCT_FULL) * (VW+7)'(thr[ssp_pkg::T_LIM_MAX] - stack_v);
        if (stack_v >= thr[ssp_pkg::T_LIM_MAX])
            chg_pct = 7'h00;
        else if (stack_v <= thr[ssp_pkg::T_LIM_HIGH])
            chg_pct = ssp_pkg::PCT_FULL;
        else
            chg_pct = 7'(num_c / (VW+7)'(thr[ssp_pkg::T_LIM_MAX] - thr[ssp_pkg::T_LIM_HIGH]));
    end

    // Discharge limit ramps from full at low breakpoint to zero at min
    always_comb
    begin
        num_d = (VW+7)'(ssp_pkg::PCT_FULL) * (VW+7)'(stack_v - thr[ssp_pkg::T_LIM_MIN]);
        if (stack_v <= thr[ssp_pkg::T_LIM_MIN])
            dchg_pct = 7'h00;
        else if (stack_v >= thr[ssp_pkg::T_LIM_LOW])
            dchg_pct = ssp_pkg::PCT_FULL;
        else
            dchg_pct = 7'(num_d / (VW+7)'(thr[ssp_pkg::T_LIM_LOW] - thr[ssp_pkg::T_LIM_MIN]));
    end

endmodule // ssp_eval
`default_nettype wire

// ---- design/ssp_pkg.sv ----
// =====================================================================
// Shared constants and types of the stack protection sequencer
// =====================================================================
package ssp_pkg;

    // Bus decode
    localparam int ADDR_W = 8;
    localparam logic [7:0] OFF_CTRL = 8'h00;
    localparam logic [7:0] OFF_HEARTBEAT = 8'h04;
    localparam logic [7:0] OFF_HB_PERIOD = 8'h08;
    localparam logic [7:0] OFF_SEQ_DLY = 8'h0C;
    localparam logic [7:0] OFF_PRECH_DLY = 8'h10;
    localparam logic [7:0] OFF_STATUS = 8'h14;
    localparam logic [7:0] OFF_THR_BASE = 8'h20;

    // Control register fields
    localparam int CTRL_AUTO = 0;
    localparam int CTRL_HB_DIS = 1;
    localparam int CTRL_CONN_REQ = 2;
    localparam int CTRL_PRECH_DIS = 3;
    localparam int CTRL_CLEAR = 4;
    localparam logic [3:0] CTRL_RST = 4'h0;

    // Threshold slots, highest voltage first down to lockout, then user high, user low and mismatch
    localparam int THR_N = 14;
    localparam int THR_WORDS = 7;
    localparam int T_OVER = 0;
    localparam int T_HI_FAULT = 1;
    localparam int T_HI_WARN = 2;
    localparam int T_LIM_MAX = 3;
    localparam int T_LIM_HIGH = 4;
    localparam int T_LIM_LOW = 5;
    localparam int T_LIM_MIN = 6;
    localparam int T_LO_WARN = 7;
    localparam int T_LO_FAULT = 8;
    localparam int T_UNDER = 9;
    localparam int T_LOCKOUT = 10;
    localparam int T_USER_HI = 11;
    localparam int T_USER_LO = 12;
    localparam int T_MISMATCH = 13;
    localparam logic [THR_N-1:0][15:0] THR_RST = {
        16'h0F00, 16'h0000, 16'hFFFF, 16'h4800, 16'h5000, 16'h5800, 16'h6000,
        16'h6800, 16'h7000, 16'hD000, 16'hD800, 16'hE000, 16'hE800, 16'hF000};

    // Timing: delays and watchdog count in milliseconds
    localparam int CLK_PERIOD_NS = 40;
    localparam int TICK_NS = 1000000;
    localparam int TICK_CYC = TICK_NS / CLK_PERIOD_NS;
    localparam logic [15:0] HB_PERIOD_RST = 16'h1388;
    localparam logic [15:0] CONN_DLY_RST = 16'h03E8;
    localparam logic [15:0] DISC_DLY_RST = 16'h03E8;
    localparam logic [15:0] PRECH_DLY_RST = 16'h07D0;

    localparam logic [6:0] PCT_FULL = 7'h64;

    typedef enum logic [4:0] {
        ST_DISC = 5'h01,
        ST_PRECH = 5'h02,
        ST_CDLY = 5'h04,
        ST_CONN = 5'h08,
        ST_DDLY = 5'h10
    } ssp_state_t;

    typedef struct packed {
        logic over_fault;
        logic hi_fault;
        logic hi_warn;
        logic lo_warn;
        logic lo_fault;
        logic under_fault;
        logic lockout;
        logic user_hi;
        logic user_lo;
        logic mismatch;
    } ssp_flags_t;

endpackage

// ---- design/ssp_top.sv ----
// Chosen here: the placing of the registers and the AHB-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// - Stack voltage checked against ordered thresholds, over-fault down to lockout.
// - Over and under faults latch until software clears them.
// - Above the high warning limit a warning is raised.
// - Below the low warning limit a warning is raised.
// - Beyond high or low fault limit a fault is raised.
// - Charge limit reaches zero at the maximum breakpoint.
// - Charge limit falls below full above the high breakpoint.
// - Discharge limit falls from full at low, zero at minimum breakpoint.
// - Lockout trigger only flags low voltage; shutdown is external.
// - Two user triggers for voltage above high or below low setting.
// - Stack versus cell sum mismatch beyond limit raises a fault.
// - Mismatch limit should be a few percent of over-fault limit.
// - Missing heartbeat within period trips watchdog fault; default five seconds.
// - Watchdog disable bit 0 enables fault, 1 ignores heartbeat loss.
// - Pre-charge switch closed during pre-charge and, unless pre-charge is disabled, the connection delay, opened on fault.
// - Main switch closed only after pre-charge completes or when pre-charge is disabled, opened on fault.
// - Stack switch closed when pre-charge or main closed, opened on fault.
// - Sequencing delay before entering and after leaving connected state.
// - Current limits active only when connected, zero otherwise.
// - Auto-connect starts connecting once software sets it (off at reset) or after faults clear.
// - Without auto-connect wait for request; never connect with faults.
// - Faults disconnect at once, skipping the disconnect delay.
module ssp_top #(
    parameter int VW = 16,
    parameter int TICK_CYCLES = ssp_pkg::TICK_CYC
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    input wire logic [VW-1:0] stack_v,
    input wire logic [VW-1:0] cell_sum_v,
    input wire logic meas_valid,
    output logic precharge_sw,
    output logic main_sw,
    output logic stack_sw,
    output logic lockout_trig,
    output logic user_hi_trig,
    output logic user_lo_trig,
    output logic fault_active,
    output logic warn_active,
    output logic [6:0] chg_limit_pct,
    output logic [6:0] dchg_limit_pct
);

    // =================================================================
    // Elaboration checks
    // =================================================================
    if (VW < 8 || VW > 16)
        $error("VW must lie in 8..16");
    if (TICK_CYCLES < 1 || TICK_CYCLES > 65535)
        $error("TICK_CYCLES must lie in 1..65535");

    // =================================================================
    // Declarations
    // =================================================================
    logic acc;
    logic wr_en_r;
    logic [7:0] wr_addr_r;
    logic [3:0] ctrl_r;
    logic clr_p;
    logic kick_p;
    logic [15:0] hb_period_r;
    logic [15:0] conn_dly_r;
    logic [15:0] disc_dly_r;
    logic [15:0] prech_dly_r;
    logic [ssp_pkg::THR_N-1:0][VW-1:0] thr_r;
    ssp_pkg::ssp_flags_t ev;
    ssp_pkg::ssp_flags_t flags_r;
    logic [6:0] ev_chg;
    logic [6:0] ev_dchg;
    logic [6:0] chg_pct_r;
    logic [6:0] dchg_pct_r;
    logic [15:0] tick_cnt_r;
    logic tick_r;
    logic [15:0] hb_cnt_r;
    logic hb_fault_r;
    logic fault_any;
    logic want;
    ssp_pkg::ssp_state_t state_r;
    ssp_pkg::ssp_state_t state_nxt;
    logic [15:0] dly_cnt_r;
    logic [15:0] cur_dly;
    logic dly_done;
    logic [31:0] rdata;

    // =================================================================
    // AHB-Lite slave
    // =================================================================
    assign acc = hsel && htrans[1] && hready;

    // Address phase capture for the write data phase
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            wr_en_r <= 1'b0;
            wr_addr_r <= 8'h00;
        end
        else
        begin
            wr_en_r <= acc && hwrite && haddr[31:ssp_pkg::ADDR_W] == '0;   // Upper address bits must be zero
            wr_addr_r <= haddr[ssp_pkg::ADDR_W-1:0];
        end
    end

    // Zero wait state, always OKAY
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            hreadyout <= 1'b0;
            hresp <= 1'b0;
        end
        else
        begin
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end
    end

    // Read mux, unmapped reads as zero
    always_comb
    begin
        rdata = 32'h0000_0000;
        if (haddr[31:ssp_pkg::ADDR_W] == '0)
        begin
            unique case (haddr[ssp_pkg::ADDR_W-1:0])
                ssp_pkg::OFF_CTRL: rdata = {28'h000_0000, ctrl_r};
                ssp_pkg::OFF_HB_PERIOD: rdata = {16'h0000, hb_period_r};
                ssp_pkg::OFF_SEQ_DLY: rdata = {disc_dly_r, conn_dly_r};
                ssp_pkg::OFF_PRECH_DLY: rdata = {16'h0000, prech_dly_r};
                ssp_pkg::OFF_STATUS: rdata = {1'b0, dchg_limit_pct, 1'b0, chg_limit_pct,
                                              state_r, hb_fault_r, flags_r};
                default:
                begin
                    for (int k = 0; k < ssp_pkg::THR_WORDS; k++)
                    begin
                        if (haddr[ssp_pkg::ADDR_W-1:0] == ssp_pkg::OFF_THR_BASE + 8'(4 * k))
                        begin
                            rdata[VW-1:0] = thr_r[2 * k];
                            rdata[16 +: VW] = thr_r[2 * k + 1];
                        end
                    end
                end
            endcase
        end
    end

    // Read data registered into the data phase
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            hrdata <= 32'h0000_0000;
        else
            hrdata <= (acc && !hwrite) ? rdata : 32'h0000_0000;
    end

    assign clr_p = wr_en_r && wr_addr_r == ssp_pkg::OFF_CTRL && hwdata[ssp_pkg::CTRL_CLEAR];
    assign kick_p = wr_en_r && wr_addr_r == ssp_pkg::OFF_HEARTBEAT;

    // Control, timing and threshold registers
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            ctrl_r <= ssp_pkg::CTRL_RST;
            hb_period_r <= ssp_pkg::HB_PERIOD_RST;
            conn_dly_r <= ssp_pkg::CONN_DLY_RST;
            disc_dly_r <= ssp_pkg::DISC_DLY_RST;
            prech_dly_r <= ssp_pkg::PRECH_DLY_RST;
            for (int i = 0; i < ssp_pkg::THR_N; i++)
                thr_r[i] <= VW'(ssp_pkg::THR_RST[i] >> (16 - VW));
        end
        else if (wr_en_r)
        begin
            if (wr_addr_r == ssp_pkg::OFF_CTRL)
                ctrl_r <= hwdata[3:0];
            if (wr_addr_r == ssp_pkg::OFF_HB_PERIOD)
                hb_period_r <= hwdata[15:0];
            if (wr_addr_r == ssp_pkg::OFF_SEQ_DLY)
            begin
                conn_dly_r <= hwdata[15:0];
                disc_dly_r <= hwdata[31:16];
            end
            if (wr_addr_r == ssp_pkg::OFF_PRECH_DLY)
                prech_dly_r <= hwdata[15:0];
            for (int k = 0; k < ssp_pkg::THR_WORDS; k++)
            begin
                if (wr_addr_r == ssp_pkg::OFF_THR_BASE + 8'(4 * k))
                begin
                    thr_r[2 * k] <= hwdata[VW-1:0];
                    thr_r[2 * k + 1] <= hwdata[16 +: VW];
                end
            end
        end
    end

    // =================================================================
    // Measurement evaluation
    // =================================================================
    ssp_eval #(
        .VW(VW)
    ) u_eval (
        .stack_v(stack_v),
        .cell_sum_v(cell_sum_v),
        .thr(thr_r),
        .flags(ev),
        .chg_pct(ev_chg),
        .dchg_pct(ev_dchg)
    );

    // Flags refreshed per update; over and under latch, set beats clear
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            flags_r <= '0;
            chg_pct_r <= 7'h00;
            dchg_pct_r <= 7'h00;
        end
        else
        begin
            if (meas_valid)
            begin
                flags_r <= ev;
                chg_pct_r <= ev_chg;
                dchg_pct_r <= ev_dchg;
            end
            flags_r.over_fault <= (meas_valid && ev.over_fault) || (flags_r.over_fault && !clr_p);
            flags_r.under_fault <= (meas_valid && ev.under_fault) || (flags_r.under_fault && !clr_p);
        end
    end

    // =================================================================
    // Millisecond tick and heartbeat watchdog
    // =================================================================
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            tick_cnt_r <= 16'h0000;
            tick_r <= 1'b0;
        end
        else
        begin
            tick_r <= tick_cnt_r == 16'(TICK_CYCLES - 1);
            tick_cnt_r <= (tick_cnt_r == 16'(TICK_CYCLES - 1)) ? 16'h0000 : tick_cnt_r + 16'h0001;
        end
    end

    // Heartbeat age counter, held at zero while disabled
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            hb_cnt_r <= 16'h0000;
        else if (ctrl_r[ssp_pkg::CTRL_HB_DIS] || kick_p)
            hb_cnt_r <= 16'h0000;
        else if (tick_r && hb_cnt_r != 16'hFFFF)
            hb_cnt_r <= hb_cnt_r + 16'h0001;
    end

    // Watchdog fault latches until cleared
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            hb_fault_r <= 1'b0;
        else
            hb_fault_r <= (!ctrl_r[ssp_pkg::CTRL_HB_DIS] && hb_cnt_r >= hb_period_r)
                          || (hb_fault_r && !clr_p);
    end

    // =================================================================
    // Connection sequencer
    // =================================================================
    assign fault_any = flags_r.over_fault || flags_r.under_fault || flags_r.hi_fault
                       || flags_r.lo_fault || flags_r.mismatch || hb_fault_r;
    assign want = ctrl_r[ssp_pkg::CTRL_AUTO] || ctrl_r[ssp_pkg::CTRL_CONN_REQ];

    // Delay length of the current state
    always_comb
    begin
        unique case (state_r)
            ssp_pkg::ST_PRECH: cur_dly = prech_dly_r;
            ssp_pkg::ST_CDLY: cur_dly = conn_dly_r;
            ssp_pkg::ST_DDLY: cur_dly = disc_dly_r;
            default: cur_dly = 16'h0000;
        endcase
    end
    assign dly_done = dly_cnt_r >= cur_dly;

    // Next state; any fault forces disconnection
    always_comb
    begin
        state_nxt = state_r;
        unique case (state_r)
            ssp_pkg::ST_DISC:
                if (!fault_any && want)
                    state_nxt = ctrl_r[ssp_pkg::CTRL_PRECH_DIS] ? ssp_pkg::ST_CDLY : ssp_pkg::ST_PRECH;
            ssp_pkg::ST_PRECH:
                if (!want)
                    state_nxt = ssp_pkg::ST_DISC;
                else if (dly_done)
                    state_nxt = ssp_pkg::ST_CDLY;
            ssp_pkg::ST_CDLY:
                if (!want)
                    state_nxt = ssp_pkg::ST_DISC;
                else if (dly_done)
                    state_nxt = ssp_pkg::ST_CONN;
            ssp_pkg::ST_CONN:
                if (!want)
                    state_nxt = ssp_pkg::ST_DDLY;
            ssp_pkg::ST_DDLY:
                if (dly_done)
                    state_nxt = ssp_pkg::ST_DISC;
            default:
                state_nxt = ssp_pkg::ST_DISC;
        endcase
        if (fault_any)
            state_nxt = ssp_pkg::ST_DISC;
    end

    // State and delay counter
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            state_r <= ssp_pkg::ST_DISC;
            dly_cnt_r <= 16'h0000;
        end
        else
        begin
            state_r <= state_nxt;
            if (state_nxt != state_r)
                dly_cnt_r <= 16'h0000;
            else if (tick_r && dly_cnt_r != 16'hFFFF)
                dly_cnt_r <= dly_cnt_r + 16'h0001;
        end
    end

    // Switch and limit outputs
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            precharge_sw <= 1'b0;
            main_sw <= 1'b0;
            stack_sw <= 1'b0;
            chg_limit_pct <= 7'h00;
            dchg_limit_pct <= 7'h00;
        end
        else
        begin
            precharge_sw <= (state_nxt == ssp_pkg::ST_PRECH)
                            || (state_nxt == ssp_pkg::ST_CDLY && !ctrl_r[ssp_pkg::CTRL_PRECH_DIS]);
            main_sw <= state_nxt inside {ssp_pkg::ST_CDLY, ssp_pkg::ST_CONN, ssp_pkg::ST_DDLY};
            stack_sw <= state_nxt != ssp_pkg::ST_DISC;
            chg_limit_pct <= (state_nxt == ssp_pkg::ST_CONN) ? chg_pct_r : 7'h00;
            dchg_limit_pct <= (state_nxt == ssp_pkg::ST_CONN) ? dchg_pct_r : 7'h00;
        end
    end

    // Trigger and summary outputs
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            lockout_trig <= 1'b0;
            user_hi_trig <= 1'b0;
            user_lo_trig <= 1'b0;
            fault_active <= 1'b0;
            warn_active <= 1'b0;
        end
        else
        begin
            lockout_trig <= meas_valid ? ev.lockout : flags_r.lockout;
            user_hi_trig <= meas_valid ? ev.user_hi : flags_r.user_hi;
            user_lo_trig <= meas_valid ? ev.user_lo : flags_r.user_lo;
            fault_active <= fault_any;
            warn_active <= flags_r.hi_warn || flags_r.lo_warn;
        end
    end

    // =================================================================
    // Assertions
    // =================================================================
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    limit_gate_a: assert property ((chg_limit_pct != 7'h00 || dchg_limit_pct != 7'h00)
        |-> state_r == ssp_pkg::ST_CONN) else $error("limit outside connected");
    prech_only_a: assert property (precharge_sw
        |-> state_r inside {ssp_pkg::ST_PRECH, ssp_pkg::ST_CDLY}) else $error("precharge misplaced");
    main_after_a: assert property ($rose(main_sw)
        |-> $past(state_r) inside {ssp_pkg::ST_PRECH, ssp_pkg::ST_DISC}) else $error("main closed early");
    stack_or_a: assert property (stack_sw == (precharge_sw || main_sw)) else $error("stack switch wrong");
    fault_open_a: assert property (fault_any |=> !stack_sw && !main_sw && !precharge_sw)
        else $error("switch closed on fault");
    over_hold_a: assert property (flags_r.over_fault && !clr_p |=> flags_r.over_fault)
        else $error("over fault self cleared");
    hb_trip_a: assert property (!ctrl_r[ssp_pkg::CTRL_HB_DIS] && hb_cnt_r >= hb_period_r
        |=> hb_fault_r) else $error("watchdog not tripped");
    hb_disable_a: assert property ($rose(hb_fault_r) |-> !$past(ctrl_r[ssp_pkg::CTRL_HB_DIS]))
        else $error("watchdog tripped while disabled");
    conn_delay_a: assert property ($rose(state_r == ssp_pkg::ST_CONN) |-> $past(state_r) == ssp_pkg::ST_CDLY)
        else $error("connected without delay");
    refuse_conn_a: assert property (state_r == ssp_pkg::ST_DISC && fault_any |=> state_r == ssp_pkg::ST_DISC)
        else $error("connect with fault");
    meas_update_a: assert property (meas_valid |=> lockout_trig == $past(ev.lockout)
        && flags_r.hi_warn == $past(ev.hi_warn)) else $error("flags not updated");

    reach_conn_c: cover property ($rose(state_r == ssp_pkg::ST_CONN));
    hb_loss_c: cover property ($rose(hb_fault_r));
    fault_clr_c: cover property (flags_r.over_fault ##1 !flags_r.over_fault);
    disc_seq_c: cover property (state_r == ssp_pkg::ST_DDLY ##1 state_r == ssp_pkg::ST_DISC);

endmodule // ssp_top
`default_nettype wire

// ---- sim/ssp_feed.sv ----
`timescale 1ns/1ps
`default_nettype none
// ====
// Measurement feed
module ssp_feed (
    input wire logic clk,
    input wire logic [31:0] vs,
    output logic [15:0] v,
    output logic [15:0] s,
    output logic vld
);
    logic [1:0] n = 2'h0;
    // Sample every fourth cycle, inverted data in between
    always_ff @(posedge clk)
    begin
        n <= n + 2'h1;
        vld <= n == 2'h3;
        {v, s} <= n == 2'h3 ? vs : ~vs;
    end
endmodule // ssp_feed
`default_nettype wire

// ---- sim/test_stack_protect_sequencer.sv ----
`timescale 1ns/1ps
`default_nettype none
// ====
// Bus, limit and sequencing test
module test_stack_protect_sequencer;
    logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b1, hwrite = 1'b0;
    logic [1:0] htrans = 2'h0;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, rd, fd = 32'h90009000;
    wire logic hreadyout, mv, pre, mn, stk, lko, flt, wrn, uh, ul, hr;
    wire logic [15:0] sv, cs;
    wire logic [31:0] hrdata;
    wire logic [6:0] chg, dchg;
    int err_count = 0, n_checks = 0, cyc;
    logic [34:0] t [6] = '{35'h6A0031964, 35'h6C0030064, 35'h360033232, 35'h720034064, 35'h2E0037200, 35'h76000C000};
    // Clock
    initial forever #20 hclk = ~hclk;
    ssp_feed i_src (.clk(hclk), .vs(fd), .v(sv), .s(cs), .vld(mv));
    ssp_top #(.TICK_CYCLES(4)) i_dut (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata,
        .hready(hreadyout), .hreadyout, .hresp(hr), .hrdata, .stack_v(sv), .cell_sum_v(cs), .meas_valid(mv),
        .precharge_sw(pre), .main_sw(mn), .stack_sw(stk), .lockout_trig(lko), .user_hi_trig(uh),
        .user_lo_trig(ul), .fault_active(flt),
        .warn_active(wrn), .chg_limit_pct(chg), .dchg_limit_pct(dchg));
    task automatic report_and_stop;
        if (err_count == 0 && n_checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_checks++;
        err_count += int'(g !== e);
        if (g !== e)
            $display("wrong value %s expected %h seen %h", nm, e, g);
    endtask
    // Sample settled values mid-cycle, then pass the edge that acts on them
    task automatic wait_on(input logic b, input logic [2:0] e);
        logic hit;
        hit = 1'b0;
        for (cyc = 0; !hit && cyc < 30000; cyc++)
        begin
            @(negedge hclk);
            hit = b ? hreadyout === 1'b1 : {pre, mn, stk} === e;
            rd = hrdata;
            @(posedge hclk);
        end
        chk("wait", 32'h0, 32'(!hit));
        if (!hit)
            report_and_stop;
    endtask
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        haddr <= {24'h0, a};
        htrans <= 2'h2;
        hwrite <= w;
        wait_on(1'b1, 3'h0);
        htrans <= 2'h0;
        hwdata <= d;
        wait_on(1'b1, 3'h0);
    endtask
    task automatic meas(input logic [31:0] x);
        fd <= x;
        repeat (10) @(posedge hclk);
    endtask
    // Main sequence
    initial
    begin
        repeat (8) @(posedge hclk);
        hresetn <= 1'b1;
        bus(1'b0, 8'h3C, 32'h0);
        chk("unmapped", 32'h0, rd);
        chk("hresp", 32'h0, 32'(hr));
        bus(1'b1, 8'h00, 32'h6);
        wait_on(1'b0, 3'h5);
        chk("prech", 32'h0, 32'({chg, dchg}));
        wait_on(1'b0, 3'h3);
        chk("delay", 32'h1, 32'(cyc > 11980 && cyc < 12020));
        for (int i = 0; i < 6; i++)
        begin
            meas({2{t[i][34:19]}});
            chk("out", 32'(t[i][18:0]), 32'({pre, mn, stk, flt, wrn, chg, dchg}));
        end
        bus(1'b1, 8'h34, 32'h8FFF4800);
        bus(1'b1, 8'h38, 32'h0F005000);
        meas(32'h40004000);
        chk("lockout", 32'h3, 32'({pre, mn, stk, lko, flt}));
        chk("user low", 32'h1, 32'({uh, ul}));
        meas(32'h90009000);
        chk("latched", 32'h1, 32'({pre, mn, stk, flt}));
        chk("user high", 32'h2, 32'({uh, ul}));
        bus(1'b1, 8'h00, 32'h16);
        wait_on(1'b0, 3'h3);
        meas(32'h90007F00);
        chk("mismatch", 32'h1, 32'(flt));
        meas(32'h90008200);
        chk("in range", 32'h0, 32'(flt));
        bus(1'b1, 8'h00, 32'h4);
        repeat (4)
        begin
            bus(1'b1, 8'h04, 32'h0);
            meas(32'h90009000);
        end
        wait_on(1'b0, 3'h0);
        chk("watchdog", 32'h1, 32'(cyc > 19950 && cyc < 20010));
        report_and_stop;
    end
endmodule // test_stack_protect_sequencer
`default_nettype wire
